// ### hw/ppfs_pkg.sv
package ppfs_pkg;
    // port widths
    localparam int PC_WIDTH = 6;
    localparam int P2_WIDTH = 6;
    localparam int P0_WIDTH = 4;
    localparam int P4_WIDTH = 2;
    localparam int SER_COUNT = 2;
    // port 2 bit positions of each serial channel's pins
    localparam int SER_TX_BIT = 0;
    localparam int SER_CLK_BIT = 1;
    localparam int SER_RX_BIT = 2;
    localparam int SER_STRIDE = 3;
    // reset values: all inputs, pull-ups off
    localparam logic [5:0] PC_DIR_RST = 6'h00;
    localparam logic [5:0] PC_PLU_RST = 6'h00;
    localparam logic [5:0] P2_DIR_RST = 6'h00;
    localparam logic [5:0] P2_PLU_RST = 6'h00;
    localparam logic [5:0] P2_OUT_RST = 6'h00;
    localparam logic [3:0] P0_RST = 4'h0;
    localparam logic [1:0] P4_RST = 2'h0;
    localparam logic [5:0] PC_OUT_RST = 6'h00;
endpackage

// ### hw/ppfs_port_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1: every port C pin has its own direction bit.
// RL2: every port C pin has its own pull-up enable bit.
// RL3: after reset all port C pins are inputs with pull-ups off.
// RL4: serial transmit pin drives serial data only when output and serial selected.
// RL5: serial receive pin feeds the serial block when input and serial selected.
// RL6: serial clock pin is clock input or output per direction, once selected.
// RL7: serial pins act as plain port 2 pins when serial not selected.
// RL8: timer pin feeds event counter when timer input selected and pin input.
// RL9: timer pin outputs timer pulse when timer output selected and pin output.
// RL10: timer pin configured as input may enable its pull-up.
// RL11: timer pins act as plain port 0 or 4 pins when timers unused.
// RL12: plain output pins drive the latch; input pins read synchronised level.
module ppfs_port_mux
    import ppfs_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // port C configuration and latch
    input wire logic [ppfs_pkg::PC_WIDTH-1:0] i_port_c_direction,
    input wire logic [ppfs_pkg::PC_WIDTH-1:0] i_port_c_pullup_enable,
    input wire logic [ppfs_pkg::PC_WIDTH-1:0] i_port_c_latch,
    input wire logic i_port_c_load,
    // port 2 configuration and latch
    input wire logic [ppfs_pkg::P2_WIDTH-1:0] i_port_two_direction,
    input wire logic [ppfs_pkg::P2_WIDTH-1:0] i_port_two_pullup_enable,
    input wire logic [ppfs_pkg::SER_COUNT-1:0] i_port_two_function_select,
    input wire logic [ppfs_pkg::P2_WIDTH-1:0] i_port_two_latch,
    // port 0 and port 4 configuration and latch
    input wire logic [ppfs_pkg::P0_WIDTH-1:0] i_port_zero_direction,
    input wire logic [ppfs_pkg::P0_WIDTH-1:0] i_port_zero_pullup_enable,
    input wire logic [ppfs_pkg::P0_WIDTH-1:0] i_port_zero_function_select,
    input wire logic [ppfs_pkg::P0_WIDTH-1:0] i_port_zero_latch,
    input wire logic [ppfs_pkg::P4_WIDTH-1:0] i_port_four_direction,
    input wire logic [ppfs_pkg::P4_WIDTH-1:0] i_port_four_pullup_enable,
    input wire logic [ppfs_pkg::P4_WIDTH-1:0] i_port_four_function_select_a,
    input wire logic [ppfs_pkg::P4_WIDTH-1:0] i_port_four_function_select_b,
    input wire logic [ppfs_pkg::P4_WIDTH-1:0] i_port_four_latch,
    // serial peripherals
    input wire logic [ppfs_pkg::SER_COUNT-1:0] i_ser_tx_data,
    input wire logic [ppfs_pkg::SER_COUNT-1:0] i_ser_clk_out,
    output logic [ppfs_pkg::SER_COUNT-1:0] o_ser_rx_data,
    output logic [ppfs_pkg::SER_COUNT-1:0] o_ser_clk_in,
    // timer peripherals, order 0,1,4,5 then 6,7
    input wire logic [5:0] i_tmr_pulse,
    output logic [5:0] o_tmr_event,
    // pins
    input wire logic [ppfs_pkg::PC_WIDTH-1:0] i_pc_pin,
    output logic [ppfs_pkg::PC_WIDTH-1:0] o_pc_pin,
    output logic [ppfs_pkg::PC_WIDTH-1:0] o_pc_pin_oe,
    output logic [ppfs_pkg::PC_WIDTH-1:0] o_pc_pullup,
    input wire logic [ppfs_pkg::P2_WIDTH-1:0] i_p2_pin,
    output logic [ppfs_pkg::P2_WIDTH-1:0] o_p2_pin,
    output logic [ppfs_pkg::P2_WIDTH-1:0] o_p2_pin_oe,
    output logic [ppfs_pkg::P2_WIDTH-1:0] o_p2_pullup,
    input wire logic [5:0] i_tmr_pin,
    output logic [5:0] o_tmr_pin,
    output logic [5:0] o_tmr_pin_oe,
    output logic [5:0] o_tmr_pullup,
    // synchronised pin levels for port reads
    output logic [ppfs_pkg::PC_WIDTH-1:0] o_pc_read,
    output logic [ppfs_pkg::P2_WIDTH-1:0] o_p2_read,
    output logic [5:0] o_tmr_read
);
    import ppfs_pkg::*;

    logic [PC_WIDTH-1:0] pc_dir_q, pc_plu_q, pc_out_q;
    logic [PC_WIDTH-1:0] pc_s1_q, pc_s2_q;
    logic [P2_WIDTH-1:0] p2_s1_q, p2_s2_q;
    logic [5:0] tm_s1_q, tm_s2_q;
    logic [5:0] tm_dir, tm_plu, tm_in_sel, tm_out_sel, tm_latch;

    // port C control held locally so reset state is guaranteed
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pc_dir_q <= PC_DIR_RST; // RL3
            pc_plu_q <= PC_PLU_RST; // RL3
            pc_out_q <= PC_OUT_RST;
        end else if (i_port_c_load) begin
            pc_dir_q <= i_port_c_direction; // RL1
            pc_plu_q <= i_port_c_pullup_enable; // RL2
            pc_out_q <= i_port_c_latch;
        end
    end

    // two-stage synchronisers; only stage two is read
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pc_s1_q <= PC_OUT_RST;
            pc_s2_q <= PC_OUT_RST;
            p2_s1_q <= P2_OUT_RST;
            p2_s2_q <= P2_OUT_RST;
            tm_s1_q <= 6'h00;
            tm_s2_q <= 6'h00;
        end else begin
            pc_s1_q <= i_pc_pin;
            pc_s2_q <= pc_s1_q;
            p2_s1_q <= i_p2_pin;
            p2_s2_q <= p2_s1_q;
            tm_s1_q <= i_tmr_pin;
            tm_s2_q <= tm_s1_q;
        end
    end

    // port C: per-bit direction and pull-up
    always_comb begin
        o_pc_pin_oe = pc_dir_q; // RL1
        o_pc_pin = pc_out_q & pc_dir_q; // RL12
        o_pc_pullup = pc_plu_q & ~pc_dir_q; // RL2
        o_pc_read = pc_s2_q; // RL12
    end

    // port 2: serial function select per channel spreads to its three pins
    always_comb begin
        o_p2_pin = '0;
        o_ser_rx_data = '0;
        o_ser_clk_in = '0;
        for (int b = 0; b < P2_WIDTH; b++) begin
            o_p2_pin[b] = i_port_two_direction[b] & i_port_two_latch[b]; // RL7
        end
        for (int c = 0; c < SER_COUNT; c++) begin
            if (i_port_two_function_select[c]) begin
                o_p2_pin[c*SER_STRIDE+SER_TX_BIT] =
                    i_port_two_direction[c*SER_STRIDE+SER_TX_BIT] & i_ser_tx_data[c]; // RL4
                o_p2_pin[c*SER_STRIDE+SER_CLK_BIT] =
                    i_port_two_direction[c*SER_STRIDE+SER_CLK_BIT] & i_ser_clk_out[c]; // RL6
                o_ser_rx_data[c] = ~i_port_two_direction[c*SER_STRIDE+SER_RX_BIT]
                    & p2_s2_q[c*SER_STRIDE+SER_RX_BIT]; // RL5
                o_ser_clk_in[c] = ~i_port_two_direction[c*SER_STRIDE+SER_CLK_BIT]
                    & p2_s2_q[c*SER_STRIDE+SER_CLK_BIT]; // RL6
            end
        end
        // a selected receive pin never drives, even if direction says output
        o_p2_pin_oe = i_port_two_direction;
        for (int c = 0; c < SER_COUNT; c++) begin
            if (i_port_two_function_select[c]) begin
                o_p2_pin_oe[c*SER_STRIDE+SER_RX_BIT] = 1'b0;
            end
        end
        o_p2_pullup = i_port_two_pullup_enable & ~o_p2_pin_oe; // RL5 RL6
        o_p2_read = p2_s2_q;
    end

    // timer pins: bits 0..3 from port 0, 4..5 from port 4
    always_comb begin
        tm_dir = {i_port_four_direction, i_port_zero_direction};
        tm_plu = {i_port_four_pullup_enable, i_port_zero_pullup_enable};
        tm_latch = {i_port_four_latch, i_port_zero_latch};
        tm_in_sel = {i_port_four_function_select_a, i_port_zero_function_select};
        // output needs both port 4 selects, so a lone select_a stays input-only
        tm_out_sel = {i_port_four_function_select_a & i_port_four_function_select_b,
                      i_port_zero_function_select};
        o_tmr_event = tm_in_sel & ~tm_dir & tm_s2_q; // RL8
        o_tmr_pin_oe = tm_dir;
        o_tmr_pin = tm_dir & ((tm_out_sel & i_tmr_pulse) | (~tm_out_sel & tm_latch)); // RL9 RL11
        o_tmr_pullup = tm_plu & ~tm_dir; // RL10
        o_tmr_read = tm_s2_q; // RL12
    end

    a_pc_reset_input: assert property (@(posedge i_mclk) // RL3
        $fell(i_rst) |-> (o_pc_pin_oe == 6'h00 && o_pc_pullup == 6'h00))
        else $error("port C not input with pull-ups off after reset");
    a_pc_dir_load: assert property (@(posedge i_mclk) disable iff (i_rst) // RL1
        i_port_c_load |=> o_pc_pin_oe == $past(i_port_c_direction))
        else $error("port C direction not taken");
    a_pc_pullup_load: assert property (@(posedge i_mclk) disable iff (i_rst) // RL2
        i_port_c_load |=>
        o_pc_pullup == ($past(i_port_c_pullup_enable) & ~$past(i_port_c_direction)))
        else $error("port C pull-up wrong");
    a_ser_tx_drive: assert property (@(posedge i_mclk) disable iff (i_rst) // RL4
        (i_port_two_function_select[0] && i_port_two_direction[SER_TX_BIT])
        |-> o_p2_pin[SER_TX_BIT] == i_ser_tx_data[0])
        else $error("serial transmit not driven");
    a_ser_rx_path: assert property (@(posedge i_mclk) disable iff (i_rst) // RL5
        (i_port_two_function_select[0] && !i_port_two_direction[SER_RX_BIT])
        |-> o_ser_rx_data[0] == p2_s2_q[SER_RX_BIT] && !o_p2_pin_oe[SER_RX_BIT])
        else $error("serial receive path wrong");
    a_ser_clk_dir: assert property (@(posedge i_mclk) disable iff (i_rst) // RL6
        i_port_two_function_select[1] |->
        o_p2_pin_oe[SER_STRIDE+SER_CLK_BIT] == i_port_two_direction[SER_STRIDE+SER_CLK_BIT])
        else $error("serial clock direction wrong");
    a_p2_plain_io: assert property (@(posedge i_mclk) disable iff (i_rst) // RL7
        !i_port_two_function_select[0] |->
        o_p2_pin[2:0] == (i_port_two_latch[2:0] & i_port_two_direction[2:0]))
        else $error("port 2 plain pin not from latch");
    a_tmr_event_in: assert property (@(posedge i_mclk) disable iff (i_rst) // RL8
        (tm_in_sel[0] && !tm_dir[0] && $past(tm_s1_q[0])) |-> o_tmr_event[0])
        else $error("timer event input lost");
    a_tmr_pulse_out: assert property (@(posedge i_mclk) disable iff (i_rst) // RL9
        (tm_out_sel[4] && tm_dir[4]) |-> o_tmr_pin[4] == i_tmr_pulse[4])
        else $error("timer pulse not output");
    a_tmr_pullup_in: assert property (@(posedge i_mclk) disable iff (i_rst) // RL10
        tm_dir[1] |-> !o_tmr_pullup[1])
        else $error("pull-up on driving timer pin");
    a_tmr_plain_io: assert property (@(posedge i_mclk) disable iff (i_rst) // RL11
        (!tm_out_sel[2] && tm_dir[2]) |-> o_tmr_pin[2] == tm_latch[2])
        else $error("timer plain pin not from latch");
    a_pc_read_sync: assert property (@(posedge i_mclk) disable iff (i_rst) // RL12
        $past(i_rst) == 1'b0 ##0 1'b1 |-> ##2 o_pc_read == $past(i_pc_pin, 2))
        else $error("port C read not two-stage synchronised");
    a_pc_pin_latch: assert property (@(posedge i_mclk) disable iff (i_rst) // RL12
        i_port_c_load |=> o_pc_pin == ($past(i_port_c_latch) & $past(i_port_c_direction)))
        else $error("port C pin not from latch");
    a_pc_ctrl_hold: assert property (@(posedge i_mclk) disable iff (i_rst) // RL1
        !i_port_c_load |=> $stable(o_pc_pin_oe))
        else $error("port C direction changed without load");
    a_ser_rx_no_drive: assert property (@(posedge i_mclk) disable iff (i_rst) // RL5
        i_port_two_function_select[1] |-> !o_p2_pin_oe[SER_STRIDE+SER_RX_BIT])
        else $error("selected serial receive pin driven");
    a_ser_clk_in_gate: assert property (@(posedge i_mclk) disable iff (i_rst) // RL6
        (i_port_two_function_select[0] && i_port_two_direction[SER_CLK_BIT]) |-> !o_ser_clk_in[0])
        else $error("serial clock input seen while pin drives");
    a_p2_pullup_drive: assert property (@(posedge i_mclk) disable iff (i_rst) // RL6
        o_p2_pin_oe[SER_CLK_BIT] |-> !o_p2_pullup[SER_CLK_BIT])
        else $error("pull-up on driving serial clock pin");
    a_tmr_event_out: assert property (@(posedge i_mclk) disable iff (i_rst) // RL8
        i_port_four_direction[1] |-> !o_tmr_event[5])
        else $error("timer event from output pin");
    a_tmr_needs_both: assert property (@(posedge i_mclk) disable iff (i_rst) // RL9
        (i_port_four_direction[0] && !i_port_four_function_select_b[0])
        |-> o_tmr_pin[4] == i_port_four_latch[0])
        else $error("timer pulse out without both selects");
endmodule
`default_nettype wire

// ### test/ppfs_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_model #(
    parameter int W = 6
) (
    // clock
    input wire logic i_mclk,
    // device side
    input wire logic [W-1:0] i_drv,
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_pu,
    // board side
    input wire logic [W-1:0] i_ext,
    input wire logic [W-1:0] i_ext_en,
    // resolved level
    output logic [W-1:0] o_level
);
    logic [W-1:0] flt_q;
    // a floating pin toggles so a stale value never reads as valid
    // plain always so the initial value below is not a second driver
    always @(posedge i_mclk) begin
        flt_q <= ~flt_q;
    end
    initial flt_q = '0;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            o_level[i] = i_oe[i] ? i_drv[i] : i_ext_en[i] ? i_ext[i] : i_pu[i] ? 1'b1 : flt_q[i];
        end
    end
endmodule
`default_nettype wire

// ### test/ppfs_port_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ppfs_port_mux_tb;
    import ppfs_pkg::*;
    logic i_mclk = 1'b0, i_rst = 1'b1, pc_ld = 1'b0;
    logic [5:0] pc_dir = '0, pc_pu = '0, pc_lat = '0, p2_dir = '0, p2_pu = '0, p2_lat = '0;
    logic [5:0] tm_dir = '0, tm_pu = '0, tm_fa = '0, tm_fb = '0, tm_lat = '0, tm_pulse = '0;
    logic [5:0] pc_ext = '0, pc_en = '0, p2_ext = '0, p2_en = '0, tm_ext = '0, tm_en = '0;
    logic [1:0] fs2 = '0, stx = '0, sclk = '0, srx, sclki;
    logic [5:0] pco, pcoe, pcpu, pcrd, p2o, p2oe, p2pu, p2rd, tmo, tmoe, tmpu, tmrd, tev;
    logic [5:0] pcl, p2l, tml;
    int mismatches = 0, n_checks = 0;
    always #5 i_mclk = ~i_mclk;
    ppfs_port_mux ppfs_port_mux_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_port_c_direction(pc_dir), .i_port_c_pullup_enable(pc_pu), .i_port_c_latch(pc_lat),
        .i_port_c_load(pc_ld), .i_port_two_direction(p2_dir), .i_port_two_pullup_enable(p2_pu),
        .i_port_two_function_select(fs2), .i_port_two_latch(p2_lat),
        .i_port_zero_direction(tm_dir[3:0]), .i_port_zero_pullup_enable(tm_pu[3:0]),
        .i_port_zero_function_select(tm_fa[3:0]), .i_port_zero_latch(tm_lat[3:0]),
        .i_port_four_direction(tm_dir[5:4]), .i_port_four_pullup_enable(tm_pu[5:4]),
        .i_port_four_function_select_a(tm_fa[5:4]), .i_port_four_function_select_b(tm_fb[5:4]),
        .i_port_four_latch(tm_lat[5:4]), .i_ser_tx_data(stx), .i_ser_clk_out(sclk),
        .o_ser_rx_data(srx), .o_ser_clk_in(sclki), .i_tmr_pulse(tm_pulse), .o_tmr_event(tev),
        .i_pc_pin(pcl), .o_pc_pin(pco), .o_pc_pin_oe(pcoe), .o_pc_pullup(pcpu),
        .i_p2_pin(p2l), .o_p2_pin(p2o), .o_p2_pin_oe(p2oe), .o_p2_pullup(p2pu),
        .i_tmr_pin(tml), .o_tmr_pin(tmo), .o_tmr_pin_oe(tmoe), .o_tmr_pullup(tmpu),
        .o_pc_read(pcrd), .o_p2_read(p2rd), .o_tmr_read(tmrd));
    ppfs_pin_model #(.W(6)) pc_model (.i_mclk(i_mclk), .i_drv(pco), .i_oe(pcoe), .i_pu(pcpu),
        .i_ext(pc_ext), .i_ext_en(pc_en), .o_level(pcl));
    ppfs_pin_model #(.W(6)) p2_model (.i_mclk(i_mclk), .i_drv(p2o), .i_oe(p2oe), .i_pu(p2pu),
        .i_ext(p2_ext), .i_ext_en(p2_en), .o_level(p2l));
    ppfs_pin_model #(.W(6)) tm_model (.i_mclk(i_mclk), .i_drv(tmo), .i_oe(tmoe), .i_pu(tmpu),
        .i_ext(tm_ext), .i_ext_en(tm_en), .o_level(tml));
    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one settle covers registered outputs; two cover the pin synchronisers
    task automatic settle(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic t_portc();
        @(posedge i_mclk);
        pc_dir <= 6'h15; pc_pu <= 6'h2A; pc_lat <= 6'h3F; pc_ld <= 1'b1;
        settle(1);
        chk(pcoe, 6'h15);
        chk(pcpu, 6'h2A);
        chk(pco, 6'h15);
        @(posedge i_mclk);
        pc_dir <= 6'h01; pc_en <= 6'h3E; pc_ext <= 6'h2A;
        settle(1);
        chk(pcoe, 6'h01);
        settle(2);
        chk(pcrd, 6'h2B);
        $display("port c test done");
    endtask
    // mid-run reset: port C must fall back to inputs with pull-ups off
    task automatic t_reset();
        @(posedge i_mclk);
        pc_ld <= 1'b0;
        i_rst <= 1'b1;
        settle(2);
        chk(pcoe, 6'h00);
        chk(pcpu, 6'h00);
        chk(pco, 6'h00);
        @(posedge i_mclk);
        i_rst <= 1'b0;
        settle(1);
        chk(pcoe, 6'h00);
        chk(pcpu, 6'h00);
        $display("reset test done");
    endtask
    task automatic t_serial();
        @(posedge i_mclk);
        fs2 <= 2'b11; p2_dir <= 6'h0B; stx <= 2'b11; sclk <= 2'b01; p2_pu <= 6'h24;
        p2_en <= 6'h10; p2_ext <= 6'h10;
        settle(2);
        chk(p2o, 6'h0B);
        chk(p2oe, 6'h0B);
        chk(p2pu, 6'h24);
        chk({4'h0, srx}, 6'h03);
        chk({4'h0, sclki}, 6'h02);
        chk(p2rd, 6'h3F);
        @(posedge i_mclk);
        fs2 <= 2'b00; p2_dir <= 6'h3F; p2_lat <= 6'h36;
        settle(1);
        chk(p2o, 6'h36);
        chk({4'h0, srx}, 6'h00);
        $display("serial test done");
    endtask
    task automatic t_timer();
        @(posedge i_mclk);
        tm_dir <= 6'h30; tm_fa <= 6'h3F; tm_fb <= 6'h30; tm_pulse <= 6'h3F; tm_pu <= 6'h0F;
        tm_en <= 6'h03; tm_ext <= 6'h01;
        settle(2);
        chk(tev, 6'h0D);
        chk(tmo, 6'h30);
        chk(tmpu, 6'h0F);
        chk(tmoe, 6'h30);
        chk(tmrd, 6'h3D);
        @(posedge i_mclk);
        tm_fb <= 6'h00;
        settle(1);
        chk(tmo, 6'h00);
        @(posedge i_mclk);
        tm_fa <= 6'h00; tm_dir <= 6'h3F; tm_lat <= 6'h2A;
        settle(2);
        chk(tmo, 6'h2A);
        chk(tev, 6'h00);
        chk(tmoe, 6'h3F);
        $display("timer test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        settle(1);
        chk(pcoe, 6'h00);
        chk(pcpu, 6'h00);
        $display("reset release test done");
        t_portc();
        t_reset();
        t_serial();
        t_timer();
        final_report();
    end
    // all tests take well under a hundred cycles
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
